// file: ofp_regs.svh
/*
  Constants of the overfrequency protection block: timing figures, scaling,
  counting thresholds and setting defaults.
  Assumes the includer has no macros of the same names.
*/
`ifndef OFP_REGS_SVH
`define OFP_REGS_SVH

// System clock: 40 MHz, 25 ns period.
`define OFP_CLK_HZ 40000000
`define OFP_CLK_PERIOD_NS 25
// One millisecond, in ns; the trip delay counts in these units.
`define OFP_MS_NS 1000000
// Millihertz per hertz; the divide numerator is the clock rate times this.
`define OFP_MHZ_PER_HZ 36'h0003E8
// Accepted measurement window, in Hz.
`define OFP_FMIN_HZ 35
`define OFP_FMAX_HZ 75
// Consecutive valid / invalid measurements to accept / drop the frequency.
`define OFP_VALID_RUN 3'h4
`define OFP_INVALID_RUN 3'h4
// Measured values above the setting needed for a start.
`define OFP_START_RUN 3'h5
// Start drop-out hysteresis, in mHz below the start setting.
`define OFP_RESET_HYST_MHZ 18'h00065
// Start setting is in 0.01 Hz, frequency in mHz.
`define OFP_CENTI_TO_MILLI 17'h0000A
// Voltage limit is in 0.01 of rated voltage; release ratio is 8/10.
`define OFP_ULIMIT_SCALE 7'h64
`define OFP_ULIMIT_REL_NUM 4'h8
`define OFP_ULIMIT_REL_DEN 4'hA
// Setting defaults: 51.00 Hz, 0.45 rated voltage, 200 ms.
`define OFP_START_DEFAULT 13'h13EC
`define OFP_ULIMIT_DEFAULT 7'h2D
`define OFP_DELAY_DEFAULT 14'h00C8

`endif

// file: ofp_pkg.sv
/*
  Types of the overfrequency protection block.
  Assumes nothing of its surroundings.
*/
package ofp_pkg;

  // Measurement sequencer; Gray order along idle, divide, update.
  typedef enum logic [1:0] {
    OFP_MS_IDLE = 2'h0,
    OFP_MS_DIV = 2'h1,
    OFP_MS_UPD = 2'h3
  } ofp_meas_state_t;

endpackage

// file: ofp_serial_div.sv
/*
  Restoring serial divider, one quotient bit per clock.
  Assumes start is only given while busy is low and denom is non-zero.
*/
`timescale 1ns/10ps
`default_nettype none

module ofp_serial_div #(
  parameter int NW = 36,
  parameter int DW = 21
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic start,
  input wire logic [NW-1:0] numer,
  input wire logic [DW-1:0] denom,
  output logic busy,
  output logic done,
  output logic [NW-1:0] quot
);

  logic [DW:0] rem;
  logic [DW-1:0] dsr;
  logic [5:0] bits_left;
  wire [DW:0] shifted = {rem[DW-1:0], quot[NW-1]};
  wire [DW:0] trial = shifted - {1'b0, dsr};
  wire fits = ~trial[DW];

  always_ff @(posedge clk_sys)
  begin
    done <= 1'b0;
    if (reset)
    begin
      busy <= 1'b0;
      rem <= '0;
      dsr <= '0;
      quot <= '0;
      bits_left <= '0;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      rem <= '0;
      dsr <= denom;
      quot <= numer;
      bits_left <= 6'(NW);
    end
    else if (busy)
    begin
      rem <= fits ? trial : shifted;
      quot <= {quot[NW-2:0], fits};
      bits_left <= bits_left - 6'h01;
      if (bits_left == 6'h01)
      begin
        busy <= 1'b0;
        done <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// file: ofp_overfreq.sv
/*
  Overfrequency protection: zero-crossing period timing, validity
  qualification, voltage gating with hysteresis, start and delayed trip,
  with one-cycle on/off event pulses.
  Assumes voltage samples and settings are synchronous to clk_sys and that
  settings are held within their allowed ranges by the user logic.
  CLK_HZ must match the real clock rate, or every frequency and period scales with it.
*/
// Operation
// R1: Time period rising-to-rising and falling-to-falling at voltage zero crossings.
// R2: Frequency from mean of both periods, recomputed at every zero crossing.
// R3: Accept measured frequency only after four consecutive valid measurements.
// R4: After four invalid measurements force reported frequency to zero.
// R5: Evaluate only while voltage exceeds settable minimum limit, 0.01 steps.
// R6: Release voltage enable only below 0.8 times the set limit.
// R7: Assert start after five measured values above the start frequency.
// R8: Start frequency setting 40.00 to 70.00 Hz, 0.01 Hz steps, compared.
// R9: Drop start when frequency falls 101 mHz below the start setting.
// R10: Trip delay 140 to 10000 ms in 1 ms steps, latency included.
// R11: Trip delay counts from fault appearance, not from start assertion.
// R12: Start-only setting keeps start but suppresses trip.
// R13: Blocking input inhibits start and trip outputs.
// R14: General start output shows the qualified overfrequency start.
// R15: General trip asserts once the condition lasted the set delay.
// R16: Event pulse on every on and off change of start and trip.
// R17: Operation off holds all outputs inactive and suspends evaluation.
// R18: Trip drops with start; delay timer restarts on each new start.
`timescale 1ns/10ps
`default_nettype none
`include "ofp_regs.svh"

module ofp_overfreq #(
  parameter int CLK_HZ = `OFP_CLK_HZ,
  parameter int MS_CYCLES = `OFP_MS_NS / `OFP_CLK_PERIOD_NS,
  parameter int PW = 21,
  parameter int VW = 16,
  parameter logic [VW-1:0] RATED_CODE = 16'h4000
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sample_strobe,
  input wire logic signed [VW-1:0] volt_sample,
  input wire logic [VW-1:0] volt_level,
  input wire logic overfreq_block_in,
  input wire logic op_enable,
  input wire logic start_only,
  input wire logic [12:0] start_freq_centi,
  input wire logic [6:0] u_limit_centi,
  input wire logic [13:0] trip_delay_ms,
  output logic overfreq_general_start,
  output logic overfreq_general_trip,
  output logic start_on_event,
  output logic start_off_event,
  output logic trip_on_event,
  output logic trip_off_event,
  output logic [16:0] freq_mhz,
  output logic freq_valid,
  output logic volt_enabled
);

  // Clock rate is a parameter so a bench may scale it; window and numerator follow it.
  localparam logic [PW-1:0] PERIOD_MIN = PW'(CLK_HZ / `OFP_FMAX_HZ);
  localparam logic [PW-1:0] PERIOD_MAX = PW'(CLK_HZ / `OFP_FMIN_HZ);
  localparam logic [35:0] FREQ_NUM = 36'(CLK_HZ) * `OFP_MHZ_PER_HZ;
  localparam logic [PW-1:0] PERIOD_SAT = '1;
  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  // Operation off acts as a held clear of every evaluation register.
  wire run_clear = reset | ~op_enable; // R17

  ofp_pkg::ofp_meas_state_t state;
  ofp_pkg::ofp_meas_state_t next_state;

  logic prev_neg;
  logic have_sample;
  logic [PW-1:0] rise_cnt;
  logic [PW-1:0] fall_cnt;
  logic [PW-1:0] rise_period;
  logic [PW-1:0] fall_period;
  logic [1:0] rise_seen;
  logic [1:0] fall_seen;
  logic [PW-1:0] avg_period;
  logic meas_ok;
  logic [2:0] good_run;
  logic [2:0] bad_run;
  logic [2:0] over_run;
  logic [15:0] ms_presc;
  logic [13:0] fault_ms;

  // Zero-crossing detection on the sample sign.
  wire now_neg = volt_sample[VW-1];
  wire rise_x = sample_strobe & have_sample & prev_neg & ~now_neg; // R1
  wire fall_x = sample_strobe & have_sample & ~prev_neg & now_neg; // R1
  wire crossing = rise_x | fall_x;

  wire [PW-1:0] next_rise_period = rise_x ? rise_cnt : rise_period;
  wire [PW-1:0] next_fall_period = fall_x ? fall_cnt : fall_period;
  wire [1:0] next_rise_seen = rise_x ? {rise_seen[0], 1'b1} : rise_seen;
  wire [1:0] next_fall_seen = fall_x ? {fall_seen[0], 1'b1} : fall_seen;
  wire [PW:0] period_sum = {1'b0, next_rise_period} + {1'b0, next_fall_period};
  wire [PW-1:0] next_avg = period_sum[PW:1]; // R2
  wire periods_ready = next_rise_seen[1] & next_fall_seen[1];
  wire avg_in_range = (next_avg >= PERIOD_MIN) && (next_avg <= PERIOD_MAX);
  wire meas_usable = periods_ready & avg_in_range & volt_enabled; // R5

  // Voltage gate with 0.8 release ratio; products kept wide enough.
  wire [VW+6:0] volt_scaled = volt_level * `OFP_ULIMIT_SCALE;
  wire [VW+6:0] limit_scaled = u_limit_centi * RATED_CODE;
  wire [VW+10:0] volt_rel = volt_scaled * `OFP_ULIMIT_REL_DEN;
  wire [VW+10:0] limit_rel = limit_scaled * `OFP_ULIMIT_REL_NUM;
  wire volt_above = volt_scaled > limit_scaled; // R5
  wire volt_below_rel = volt_rel < limit_rel; // R6
  wire next_volt_en = volt_enabled ? ~volt_below_rel : volt_above; // R6

  // Frequency division.
  logic div_busy;
  logic div_done;
  logic [35:0] div_quot;
  wire div_start = (state == ofp_pkg::OFP_MS_IDLE) && crossing && meas_usable && !div_busy;

  ofp_serial_div #(
    .NW(36),
    .DW(PW)
  ) u_div (
    .clk_sys(clk_sys),
    .reset(run_clear),
    .start(div_start),
    .numer(FREQ_NUM),
    .denom(next_avg),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot)
  );

  // Measurement sequencer.
  always_comb
  begin
    next_state = state;
    case (state)
      ofp_pkg::OFP_MS_IDLE:
      begin
        if (crossing)
        begin
          next_state = meas_usable ? ofp_pkg::OFP_MS_DIV : ofp_pkg::OFP_MS_UPD;
        end
      end
      ofp_pkg::OFP_MS_DIV:
      begin
        if (div_done)
        begin
          next_state = ofp_pkg::OFP_MS_UPD;
        end
      end
      ofp_pkg::OFP_MS_UPD:
      begin
        next_state = ofp_pkg::OFP_MS_IDLE;
      end
      default:
      begin
        next_state = ofp_pkg::OFP_MS_IDLE;
      end
    endcase
  end

  // Validity qualification.
  wire upd = (state == ofp_pkg::OFP_MS_UPD);
  wire [2:0] next_good = meas_ok ? ((good_run == `OFP_VALID_RUN) ? good_run
                                     : good_run + 3'h1) : 3'h0;
  wire [2:0] next_bad = meas_ok ? 3'h0 : ((bad_run == `OFP_INVALID_RUN) ? bad_run
                                          : bad_run + 3'h1);
  wire accept_now = meas_ok && (next_good == `OFP_VALID_RUN); // R3
  wire zero_now = ~meas_ok && (next_bad == `OFP_INVALID_RUN); // R4
  wire [16:0] quot_freq = div_quot[16:0];
  wire [16:0] next_freq = accept_now ? quot_freq : (zero_now ? 17'h00000 : freq_mhz);
  wire next_valid = accept_now | (freq_valid & ~zero_now);

  // Start comparison with hysteresis.
  wire [16:0] start_mhz = start_freq_centi * `OFP_CENTI_TO_MILLI; // R8
  wire above_start = next_valid && (next_freq > start_mhz); // R8
  wire [17:0] freq_plus_hyst = {1'b0, next_freq} + `OFP_RESET_HYST_MHZ;
  wire below_reset = ~next_valid || (freq_plus_hyst <= {1'b0, start_mhz}); // R9
  wire [2:0] over_inc = (over_run == `OFP_START_RUN) ? over_run : over_run + 3'h1;
  wire [2:0] next_over = above_start ? over_inc : (below_reset ? 3'h0 : over_run); // R7
  wire start_cond = (over_run == `OFP_START_RUN); // R7

  // Delay timer from the first measured value above the setting.
  // The prescaler restarts with the fault, so the delay resolves to one millisecond.
  wire fault_present = (over_run != 3'h0); // R11
  wire ms_tick = (ms_presc == MS_LAST);
  wire delay_reached = (fault_ms >= trip_delay_ms); // R10

  wire next_start = op_enable & ~overfreq_block_in & start_cond; // R13 R14
  wire next_trip = next_start & ~start_only & delay_reached; // R12 R15 R18

  always_ff @(posedge clk_sys)
  begin
    if (run_clear)
    begin
      state <= ofp_pkg::OFP_MS_IDLE;
      prev_neg <= 1'b0;
      have_sample <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (sample_strobe)
      begin
        prev_neg <= now_neg;
        have_sample <= 1'b1;
      end
    end
  end

  // Free-running period counters, saturated so a lost signal reads out of range.
  always_ff @(posedge clk_sys)
  begin
    if (run_clear)
    begin
      rise_cnt <= '0;
      fall_cnt <= '0;
      rise_period <= '0;
      fall_period <= '0;
      rise_seen <= 2'h0;
      fall_seen <= 2'h0;
    end
    else
    begin
      rise_cnt <= rise_x ? PW'(1) : ((rise_cnt == PERIOD_SAT) ? rise_cnt
                                      : rise_cnt + PW'(1)); // R1
      fall_cnt <= fall_x ? PW'(1) : ((fall_cnt == PERIOD_SAT) ? fall_cnt
                                      : fall_cnt + PW'(1)); // R1
      rise_period <= next_rise_period;
      fall_period <= next_fall_period;
      rise_seen <= next_rise_seen;
      fall_seen <= next_fall_seen;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (run_clear)
    begin
      volt_enabled <= 1'b0;
    end
    else if (sample_strobe)
    begin
      volt_enabled <= next_volt_en; // R5 R6
    end
  end

  // A crossing that arrives while the divider runs is not measured; crossings
  // are milliseconds apart and the divide takes under forty cycles.
  always_ff @(posedge clk_sys)
  begin
    if (run_clear)
    begin
      avg_period <= '0;
      meas_ok <= 1'b0;
    end
    else if (state == ofp_pkg::OFP_MS_IDLE && crossing)
    begin
      avg_period <= next_avg; // R2
      meas_ok <= meas_usable;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (run_clear)
    begin
      good_run <= 3'h0;
      bad_run <= 3'h0;
      freq_mhz <= 17'h00000;
      freq_valid <= 1'b0;
      over_run <= 3'h0;
    end
    else if (upd)
    begin
      good_run <= next_good; // R3
      bad_run <= next_bad; // R4
      freq_mhz <= next_freq; // R2 R4
      freq_valid <= next_valid; // R3
      over_run <= overfreq_block_in ? 3'h0 : next_over; // R7 R9 R13
    end
    else if (overfreq_block_in)
    begin
      over_run <= 3'h0; // R13
    end
  end

  // Timer restarts whenever the overfrequency condition is gone.
  always_ff @(posedge clk_sys)
  begin
    if (run_clear || !fault_present)
    begin
      ms_presc <= 16'h0000;
      fault_ms <= 14'h0000; // R11 R18
    end
    else
    begin
      ms_presc <= ms_tick ? 16'h0000 : ms_presc + 16'h0001;
      if (ms_tick && !delay_reached)
      begin
        fault_ms <= fault_ms + 14'h0001; // R10 R11
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      overfreq_general_start <= 1'b0;
      overfreq_general_trip <= 1'b0;
    end
    else
    begin
      overfreq_general_start <= next_start; // R14 R17
      overfreq_general_trip <= next_trip; // R15 R17
    end
  end

  // Each pulse compares the next level with the registered one, so it lines up with the change.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      start_on_event <= 1'b0;
      start_off_event <= 1'b0;
      trip_on_event <= 1'b0;
      trip_off_event <= 1'b0;
    end
    else
    begin
      start_on_event <= next_start & ~overfreq_general_start; // R16
      start_off_event <= ~next_start & overfreq_general_start; // R16
      trip_on_event <= next_trip & ~overfreq_general_trip; // R16
      trip_off_event <= ~next_trip & overfreq_general_trip; // R16
    end
  end

endmodule

`default_nettype wire

// file: ofp_overfreq_asserts.sv
/* Concurrent checks of the overfrequency block, seeing only its ports.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module ofp_overfreq_chk #(
  parameter int VW = 16,
  parameter logic [VW-1:0] RATED_CODE = 16'h4000
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sample_strobe,
  input wire logic [VW-1:0] volt_level,
  input wire logic overfreq_block_in,
  input wire logic op_enable,
  input wire logic start_only,
  input wire logic [6:0] u_limit_centi,
  input wire logic overfreq_general_start,
  input wire logic overfreq_general_trip,
  input wire logic start_on_event,
  input wire logic start_off_event,
  input wire logic trip_on_event,
  input wire logic trip_off_event,
  input wire logic [16:0] freq_mhz,
  input wire logic freq_valid,
  input wire logic volt_enabled
);
  logic [31:0] lvl_x100;
  logic [31:0] lim_x;
  // Both sides scaled to integers so the 0.8 release ratio needs no division.
  assign lvl_x100 = 32'(volt_level) * 32'h64;
  assign lim_x = 32'(u_limit_centi) * 32'(RATED_CODE);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_trip_with_start: assert property (overfreq_general_trip |-> overfreq_general_start)
    else $error("trip without start");
  chk_start_event_pair: assert property (start_on_event == $rose(overfreq_general_start)
    && start_off_event == $fell(overfreq_general_start)) else $error("start event wrong");
  chk_trip_event_pair: assert property (trip_on_event == $rose(overfreq_general_trip)
    && trip_off_event == $fell(overfreq_general_trip)) else $error("trip event wrong");
  chk_block_inhibits: assert property (overfreq_block_in [*3] |->
    !overfreq_general_start && !overfreq_general_trip) else $error("output while blocked");
  chk_op_off_quiet: assert property (!op_enable [*2] |-> freq_mhz == 17'h0 &&
    !(overfreq_general_start | overfreq_general_trip | freq_valid | volt_enabled))
    else $error("output while operation off");
  chk_start_only_trip: assert property (start_only [*3] |-> !overfreq_general_trip)
    else $error("trip in start-only mode");
  chk_start_needs_valid: assert property (overfreq_general_start |-> $past(freq_valid))
    else $error("start without valid frequency");
  chk_gate_opens: assert property ($rose(volt_enabled) |-> $past(sample_strobe)
    && $past(lvl_x100) > $past(lim_x)) else $error("gate opened below limit");
  chk_gate_release: assert property ($fell(volt_enabled) && $past(op_enable) |->
    $past(sample_strobe) && $past(lvl_x100) * 32'hA < $past(lim_x) * 32'h8)
    else $error("gate released above hysteresis");
  cover property ($rose(overfreq_general_start));
  cover property ($rose(overfreq_general_trip));
  cover property ($fell(freq_valid) && op_enable);
endmodule
bind ofp_overfreq ofp_overfreq_chk #(.VW(VW), .RATED_CODE(RATED_CODE)) u_chk (.clk_sys, .reset,
  .sample_strobe, .volt_level, .overfreq_block_in, .op_enable, .start_only, .u_limit_centi,
  .overfreq_general_start, .overfreq_general_trip, .start_on_event, .start_off_event,
  .trip_on_event, .trip_off_event, .freq_mhz, .freq_valid, .volt_enabled);
`default_nettype wire

// file: ofp_wave_src.sv
/* Square-wave voltage front end for the overfrequency bench.
   Assumes one clock; it strobes a sample every second cycle. */
`timescale 1ns/10ps
`default_nettype none
module ofp_wave_src #(
  parameter int HALF = 270000
) (
  input wire logic clk_sys,
  input wire logic [15:0] amp_level,
  output logic sample_strobe,
  output logic signed [15:0] volt_sample,
  output logic [15:0] volt_level
);
  int cnt = 0;
  logic pos = 1'b1;
  // Off the strobe the lines carry a moving pattern, so a stray read shows up as junk.
  assign sample_strobe = ~cnt[0];
  assign volt_sample = sample_strobe ? (pos ? 16'sh2000 : 16'shE000) : cnt[15:0] ^ 16'hA5A5;
  assign volt_level = sample_strobe ? amp_level : ~cnt[15:0];
  always @(posedge clk_sys)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      pos <= ~pos;
  end
endmodule
`default_nettype wire

// file: testbench.sv
/* Self-checking bench of the overfrequency block fed by a square wave.
   Assumes the header, package, design and checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int HALF = 1350;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic op_enable = 1'b0;
  logic overfreq_block_in = 1'b0;
  logic start_only = 1'b0;
  logic [12:0] start_freq_centi = 13'h1B58;
  logic [6:0] u_limit_centi = 7'h2D;
  logic [13:0] trip_delay_ms = 14'h008C;
  logic [15:0] amp_level = 16'h2EE0;
  logic sample_strobe, overfreq_general_start, overfreq_general_trip, freq_valid, volt_enabled;
  logic start_on_event, start_off_event, trip_on_event, trip_off_event;
  logic signed [15:0] volt_sample;
  logic [15:0] volt_level;
  logic [16:0] freq_mhz;
  int bad_count = 0;
  int total_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  ofp_wave_src #(.HALF(HALF)) u_ofp_wave_src (.clk_sys, .amp_level, .sample_strobe,
    .volt_sample, .volt_level);
  // A scaled clock and millisecond keep the run short; the delay still spans several periods.
  ofp_overfreq #(.CLK_HZ(200000), .MS_CYCLES(100)) u_ofp_overfreq (.clk_sys, .reset,
    .sample_strobe, .volt_sample, .volt_level, .overfreq_block_in, .op_enable, .start_only,
    .start_freq_centi, .u_limit_centi, .trip_delay_ms, .overfreq_general_start,
    .overfreq_general_trip, .start_on_event, .start_off_event, .trip_on_event,
    .trip_off_event, .freq_mhz, .freq_valid, .volt_enabled);
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic pick(input int k);
    return k == 0 ? overfreq_general_start : k == 1 ? overfreq_general_trip :
      k == 2 ? freq_valid : k == 3 ? volt_enabled : freq_mhz == 17'h0;
  endfunction
  task automatic wait_for(input int k, input logic lvl, input int limit);
    int n;
    n = 0;
    while (pick(k) !== lvl && n < limit)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check(pick(k), lvl);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  initial
  begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    cyc(1000);
    check({overfreq_general_start, overfreq_general_trip, freq_valid, volt_enabled}, 17'h0);
    check(freq_mhz, 17'h0);
    @(posedge clk_sys);
    op_enable <= 1'b1;
    wait_for(2, 1'b1, 12000);
    check(freq_mhz, 17'h1215A);
    check(overfreq_general_start, 1'b0);
    wait_for(0, 1'b1, 8000);
    check(start_on_event, 1'b1);
    cyc(8000);
    check(overfreq_general_trip, 1'b0);
    wait_for(1, 1'b1, 1200);
    check(trip_on_event, 1'b1);
    @(posedge clk_sys);
    overfreq_block_in <= 1'b1;
    wait_for(0, 1'b0, 4);
    check({start_off_event, trip_off_event, overfreq_general_trip}, 17'h6);
    @(posedge clk_sys);
    overfreq_block_in <= 1'b0;
    start_only <= 1'b1;
    wait_for(0, 1'b1, 8000);
    @(posedge clk_sys);
    start_freq_centi <= 13'h1CF9;
    cyc(10000);
    check({overfreq_general_start, overfreq_general_trip}, 17'h2);
    @(posedge clk_sys);
    start_freq_centi <= 13'h1CFA;
    wait_for(0, 1'b0, 3000);
    @(posedge clk_sys);
    amp_level <= 16'h1964;
    cyc(3000);
    check({volt_enabled, freq_valid}, 17'h3);
    @(posedge clk_sys);
    amp_level <= 16'h1388;
    wait_for(3, 1'b0, 10);
    wait_for(4, 1'b1, 8000);
    check(freq_valid, 1'b0);
    @(posedge clk_sys);
    amp_level <= 16'h2EE0;
    wait_for(3, 1'b1, 10);
    @(posedge clk_sys);
    op_enable <= 1'b0;
    cyc(3);
    check(volt_enabled, 1'b0);
    give_verdict();
  end
  initial
  begin
    repeat (80000) @(posedge clk_sys);
    bad_count++;
    $display("mismatch at %0t: run took too long", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
